/* rtl/mcs_top.sv */
// Current scale, offset readback, fuse defaults and hold/run current control
// Function
// - Global scale factor multiplies into the per-coil current scaling.
// - Global scale zero acts as full scale, equal to 256.
// - Global scale 32..255 selects value/256 of maximum coil current.
// - Global scale also scales chopper hysteresis; set it first.
// - Offset result is read-only: phase A upper byte, phase B lower byte.
// - Fuse byte supplies power-up defaults for several settings.
// - Fuse bits read 0 blank; programming only sets bits, never clears.
// - Fuse bit 7 picks blank time default: 0 gives %10, 1 gives %01.
// - Fuse bit 6 picks dead-time clocks default: 0 gives 4, 1 gives 2.
// - Fuse bit 5 sets both short thresholds default: 0 gives 6, 1 gives 12.
// - Fuse bits 4..0 give oscillator trim default and stay unaltered.
// - Hold current code 0..31 gives 1/32..32/32 of scaled current.
// - Run current code uses the same 32-step encoding while moving.
// - Quiet mode with hold zero lets standstill be freewheel or shorted coils.
// - Hold ramp delay field sets clocks for smooth reduction to hold.
// - Delay 0 drops instantly; codes 1..15 wait that many 2^18 clocks per step.
// - Reduction starts only after standstill and expired power-down delay.
`timescale 1ns/1ns
module mcs_top #(
   parameter int RAMP_UNIT_CLKS = mcs_pkg::RAMP_UNIT_CLKS_DEF
) (
   input wire logic mclk,
   input wire logic arst_n,
   input wire logic spi_cs_n,
   input wire logic spi_sck,
   input wire logic spi_sdi,
   output logic spi_sdo,
   output logic spi_sdo_oe_n,
   input wire logic [7:0] offset_cal_a,
   input wire logic [7:0] offset_cal_b,
   input wire logic fuse_prog_en,
   input wire logic [7:0] fuse_prog_bits,
   input wire logic standstill,
   input wire logic powerdown_expired,
   input wire logic quiet_pwm_mode,
   input wire logic standstill_short_sel,
   output logic [1:0] blank_time_select,
   output logic [3:0] digital_deadtime_clocks,
   output logic [3:0] ground_short_threshold,
   output logic [3:0] supply_short_threshold,
   output logic [4:0] osc_trim,
   output logic [13:0] current_ref,
   output logic [8:0] hyst_scale,
   output logic coil_freewheel,
   output logic coil_short
);
   // ==========================================================
   // Arithmetic helpers
   function automatic logic [8:0] eff_scale(input logic [7:0] code);
      logic [8:0] r;
      r = {1'b0, code};
      if (code == 8'h00) begin
         r = mcs_pkg::FULL_SCALE;
      end
      return r;
   endfunction

   // Result is in units of 1/8192 of maximum coil current
   function automatic logic [13:0] scaled_ref(input logic [8:0] gs, input logic [4:0] lvl);
      logic [14:0] p;
      p = 15'(gs) * 15'({1'b0, lvl} + 6'h01);
      return p[13:0];
   endfunction

   function automatic logic [1:0] pick2(input logic sel, input logic [1:0] a, input logic [1:0] b);
      return sel ? b : a;
   endfunction

   function automatic logic [3:0] pick4(input logic sel, input logic [3:0] a, input logic [3:0] b);
      return sel ? b : a;
   endfunction

   // ==========================================================
   // Fuse memory
   logic [7:0] fuse_rd;

   mcs_fuse mcs_fuse_i (
      .mclk(mclk),
      .arst_n(arst_n),
      .prog_en(fuse_prog_en),
      .prog_bits(fuse_prog_bits),
      .rd_data(fuse_rd)
   );

   // ==========================================================
   // State
   mcs_pkg::mcs_state_t s_q;
   mcs_pkg::mcs_state_t s_d;

   logic [21:0] step_clks;
   logic [7:0] frame_addr;
   logic [6:0] reg_addr;
   logic [31:0] frame_data;
   logic sck_rise;
   logic sck_fall;
   logic cs_fall;
   logic cs_rise;
   logic [39:0] next_out;

   always_comb begin
      s_d = s_q;
      step_clks = mcs_pkg::RAMP_CNT_W'(int'(s_q.hold_ramp_delay) * RAMP_UNIT_CLKS);
      frame_addr = s_q.shin[mcs_pkg::ADDR_MSB:mcs_pkg::ADDR_LSB];
      reg_addr = frame_addr[6:0];
      frame_data = s_q.shin[31:0];
      sck_rise = !s_q.sck_prev && spi_sck;
      sck_fall = s_q.sck_prev && !spi_sck;
      cs_fall = s_q.cs_prev && !spi_cs_n;
      cs_rise = !s_q.cs_prev && spi_cs_n;
      next_out = {s_q.shout[38:0], 1'b0};

      s_d.sck_prev = spi_sck;
      s_d.cs_prev = spi_cs_n;
      s_d.sdo_oe_n = spi_cs_n;

      // ==========================================================
      // Serial slave: sample on rising clock, shift out on falling clock
      if (cs_fall) begin
         s_d.bit_cnt = 6'h00;
         s_d.shout = {mcs_pkg::SPI_STATUS_BYTE, s_q.rdata};
         s_d.sdo = mcs_pkg::SPI_STATUS_BYTE[7];
      end else if (!spi_cs_n) begin
         if (sck_rise) begin
            s_d.shin = {s_q.shin[38:0], spi_sdi};
            if (s_q.bit_cnt != mcs_pkg::FRAME_BITS_CNT) begin
               s_d.bit_cnt = s_q.bit_cnt + 6'h01;
            end
         end
         // The first fall presents bit 39 again so the master sees it on the first rise
         if (sck_fall) begin
            s_d.shout = next_out;
            s_d.sdo = s_q.shout[mcs_pkg::FRAME_BITS - 1];
         end
      end

      // Only frames of at least 40 bits act; short frames are dropped whole, long frames act on their last 40 bits
      if (cs_rise && s_q.bit_cnt == mcs_pkg::FRAME_BITS_CNT) begin
         if (frame_addr[mcs_pkg::WRITE_FLAG_BIT]) begin
            if (reg_addr == mcs_pkg::ADDR_CURRENT_SCALE_FACTOR) begin
               s_d.scale = frame_data[7:0];
            end else if (reg_addr == mcs_pkg::ADDR_CURRENT_LEVELS) begin
               s_d.hold_current = frame_data[mcs_pkg::HOLD_LSB +: 5];
               s_d.run_current = frame_data[mcs_pkg::RUN_LSB +: 5];
               s_d.hold_ramp_delay = frame_data[mcs_pkg::DELAY_LSB +: 4];
            end
            s_d.rdata = 32'h0000_0000;
         end else begin
            // Write-only and unmapped registers read as zero
            if (reg_addr == mcs_pkg::ADDR_FUSE_READBACK) begin
               s_d.rdata = {24'h00_0000, fuse_rd};
            end else if (reg_addr == mcs_pkg::ADDR_OFFSET_CAL_RESULT) begin
               s_d.rdata = {16'h0000, offset_cal_a, offset_cal_b};
            end else begin
               s_d.rdata = 32'h0000_0000;
            end
         end
      end

      // ==========================================================
      // Power-up defaults taken once from the fuse after reset release
      if (s_q.load_pending) begin
         s_d.load_pending = 1'b0;
         s_d.defaults.blank_time_select = pick2(fuse_rd[mcs_pkg::FUSE_BLANK_BIT],
            mcs_pkg::BLANK_CODE_FUSE0, mcs_pkg::BLANK_CODE_FUSE1);
         s_d.defaults.digital_deadtime_clocks = pick4(fuse_rd[mcs_pkg::FUSE_DEADTIME_BIT],
            mcs_pkg::DEADTIME_FUSE0, mcs_pkg::DEADTIME_FUSE1);
         s_d.defaults.ground_short_threshold = pick4(fuse_rd[mcs_pkg::FUSE_SHORT_BIT],
            mcs_pkg::SHORT_LEVEL_FUSE0, mcs_pkg::SHORT_LEVEL_FUSE1);
         s_d.defaults.supply_short_threshold = pick4(fuse_rd[mcs_pkg::FUSE_SHORT_BIT],
            mcs_pkg::SHORT_LEVEL_FUSE0, mcs_pkg::SHORT_LEVEL_FUSE1);
         s_d.defaults.osc_trim = fuse_rd[mcs_pkg::FUSE_TRIM_MSB:0];
      end

      // ==========================================================
      // Run / hold current sequencing
      case (s_q.ramp)
         mcs_pkg::MCS_RUN: begin
            s_d.level = s_q.run_current;
            s_d.ramp_cnt = '0;
            if (standstill && powerdown_expired) begin
               if (s_q.hold_ramp_delay == 4'h0) begin
                  s_d.level = s_q.hold_current;
                  s_d.ramp = mcs_pkg::MCS_HOLD;
               end else begin
                  s_d.ramp = mcs_pkg::MCS_RAMP;
               end
            end
         end
         mcs_pkg::MCS_RAMP: begin
            if (!standstill) begin
               s_d.level = s_q.run_current;
               s_d.ramp = mcs_pkg::MCS_RUN;
            end else if (s_q.level <= s_q.hold_current || s_q.hold_ramp_delay == 4'h0) begin
               s_d.level = s_q.hold_current;
               s_d.ramp = mcs_pkg::MCS_HOLD;
            end else if (s_q.ramp_cnt + 22'h00_0001 >= step_clks) begin
               s_d.level = s_q.level - 5'h01;
               s_d.ramp_cnt = '0;
            end else begin
               s_d.ramp_cnt = s_q.ramp_cnt + 22'h00_0001;
            end
         end
         mcs_pkg::MCS_HOLD: begin
            s_d.level = s_q.hold_current;
            if (!standstill) begin
               s_d.level = s_q.run_current;
               s_d.ramp = mcs_pkg::MCS_RUN;
            end
         end
         default: begin
            s_d.ramp = mcs_pkg::MCS_RUN;
         end
      endcase

      s_d.current_ref = scaled_ref(eff_scale(s_q.scale), s_q.level);
      s_d.hyst_scale = eff_scale(s_q.scale);

      // Standstill coil handling applies only once the hold level is reached
      s_d.coil_freewheel = 1'b0;
      s_d.coil_short = 1'b0;
      if (quiet_pwm_mode && s_q.hold_current == 5'h00 && s_q.ramp == mcs_pkg::MCS_HOLD) begin
         s_d.coil_freewheel = !standstill_short_sel;
         s_d.coil_short = standstill_short_sel;
      end
   end

   // ==========================================================
   // Registers
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         s_q <= '0;
         s_q.ramp <= mcs_pkg::MCS_RUN;
         s_q.sck_prev <= 1'b1;
         s_q.cs_prev <= 1'b1;
         s_q.sdo_oe_n <= 1'b1;
         s_q.scale <= mcs_pkg::SCALE_RESET;
         s_q.hold_current <= mcs_pkg::LEVEL_RESET;
         s_q.run_current <= mcs_pkg::LEVEL_RESET;
         s_q.hold_ramp_delay <= mcs_pkg::DELAY_RESET;
         s_q.load_pending <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   assign spi_sdo = s_q.sdo;
   assign spi_sdo_oe_n = s_q.sdo_oe_n;
   assign blank_time_select = s_q.defaults.blank_time_select;
   assign digital_deadtime_clocks = s_q.defaults.digital_deadtime_clocks;
   assign ground_short_threshold = s_q.defaults.ground_short_threshold;
   assign supply_short_threshold = s_q.defaults.supply_short_threshold;
   assign osc_trim = s_q.defaults.osc_trim;
   assign current_ref = s_q.current_ref;
   assign hyst_scale = s_q.hyst_scale;
   assign coil_freewheel = s_q.coil_freewheel;
   assign coil_short = s_q.coil_short;
endmodule

/* rtl/mcs_pkg.sv */
// Package of constants, types and state records for the motor current scale block
package mcs_pkg;
   // ==========================================================
   // Register map
   localparam logic [6:0] ADDR_FUSE_READBACK = 7'h07;
   localparam logic [6:0] ADDR_CURRENT_SCALE_FACTOR = 7'h0b;
   localparam logic [6:0] ADDR_OFFSET_CAL_RESULT = 7'h0c;
   localparam logic [6:0] ADDR_CURRENT_LEVELS = 7'h10;

   // ==========================================================
   // Serial frame layout
   localparam int FRAME_BITS = 40;
   localparam logic [5:0] FRAME_BITS_CNT = 6'h28;
   localparam int ADDR_MSB = 39;
   localparam int ADDR_LSB = 32;
   localparam int WRITE_FLAG_BIT = 7;
   localparam logic [7:0] SPI_STATUS_BYTE = 8'h00;

   // ==========================================================
   // Field positions of current_levels
   localparam int HOLD_LSB = 0;
   localparam int RUN_LSB = 8;
   localparam int DELAY_LSB = 16;

   // ==========================================================
   // Current scale
   localparam logic [8:0] FULL_SCALE = 9'h100;
   localparam logic [7:0] SCALE_RESET = 8'h00;
   localparam logic [4:0] LEVEL_RESET = 5'h00;
   localparam logic [3:0] DELAY_RESET = 4'h0;

   // ==========================================================
   // Fuse bit positions and the defaults they pick
   localparam int FUSE_BLANK_BIT = 7;
   localparam int FUSE_DEADTIME_BIT = 6;
   localparam int FUSE_SHORT_BIT = 5;
   localparam int FUSE_TRIM_MSB = 4;
   localparam logic [7:0] FUSE_TRIM_MASK = 8'h1f;
   localparam logic [7:0] FUSE_BLANK = 8'h00;
   localparam logic [1:0] BLANK_CODE_FUSE0 = 2'h2;
   localparam logic [1:0] BLANK_CODE_FUSE1 = 2'h1;
   localparam logic [3:0] DEADTIME_FUSE0 = 4'h4;
   localparam logic [3:0] DEADTIME_FUSE1 = 4'h2;
   localparam logic [3:0] SHORT_LEVEL_FUSE0 = 4'h6;
   localparam logic [3:0] SHORT_LEVEL_FUSE1 = 4'hc;
   // Arbitrary factory image; real trim differs per part
   localparam logic [7:0] FUSE_FACTORY_DEF = 8'h10;

   // ==========================================================
   // Hold ramp timing
   localparam int RAMP_UNIT_CLKS_DEF = 262144;
   localparam int RAMP_CNT_W = 22;

   typedef enum logic [1:0] {MCS_RUN, MCS_RAMP, MCS_HOLD} mcs_ramp_state_t;

   typedef struct packed {
      logic [7:0] fuse;
      logic [7:0] rd;
   } mcs_fuse_state_t;

   typedef struct packed {
      logic [1:0] blank_time_select;
      logic [3:0] digital_deadtime_clocks;
      logic [3:0] ground_short_threshold;
      logic [3:0] supply_short_threshold;
      logic [4:0] osc_trim;
   } mcs_defaults_t;

   typedef struct packed {
      mcs_ramp_state_t ramp;
      logic sck_prev;
      logic cs_prev;
      logic [5:0] bit_cnt;
      logic [39:0] shin;
      logic [39:0] shout;
      logic sdo;
      logic sdo_oe_n;
      logic [31:0] rdata;
      logic [7:0] scale;
      logic [4:0] hold_current;
      logic [4:0] run_current;
      logic [3:0] hold_ramp_delay;
      logic [4:0] level;
      logic [21:0] ramp_cnt;
      logic load_pending;
      mcs_defaults_t defaults;
      logic [13:0] current_ref;
      logic [8:0] hyst_scale;
      logic coil_freewheel;
      logic coil_short;
   } mcs_state_t;
endpackage

/* rtl/mcs_fuse.sv */
// One-time-programmable fuse byte with registered read port
`timescale 1ns/1ns
module mcs_fuse #(
   parameter logic [7:0] FACTORY_IMAGE = mcs_pkg::FUSE_FACTORY_DEF
) (
   input wire logic mclk,
   input wire logic arst_n,
   input wire logic prog_en,
   input wire logic [7:0] prog_bits,
   output logic [7:0] rd_data
);
   mcs_pkg::mcs_fuse_state_t s_q;
   mcs_pkg::mcs_fuse_state_t s_d;

   always_comb begin
      s_d = s_q;
      // Trim bits are locked so that factory tuning survives any programming
      if (prog_en) begin
         s_d.fuse = s_q.fuse | (prog_bits & ~mcs_pkg::FUSE_TRIM_MASK);
      end
      s_d.rd = s_q.fuse;
   end

   // Reset reloads FACTORY_IMAGE, so bits programmed since the last reset are lost
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         s_q <= '{fuse: FACTORY_IMAGE, rd: FACTORY_IMAGE};
      end else begin
         s_q <= s_d;
      end
   end

   assign rd_data = s_q.rd;
endmodule

/* dv/mcs_top_assertions.sv */
// Concurrent checks on the current scale block outputs
`timescale 1ns/1ns
// ==========================================================
// Output relations
module mcs_top_assertions (
   input wire logic mclk,
   input wire logic arst_n,
   input wire logic spi_cs_n,
   input wire logic spi_sdo_oe_n,
   input wire logic quiet_pwm_mode,
   input wire logic standstill_short_sel,
   input wire logic [1:0] blank_time_select,
   input wire logic [3:0] digital_deadtime_clocks,
   input wire logic [3:0] ground_short_threshold,
   input wire logic [3:0] supply_short_threshold,
   input wire logic [4:0] osc_trim,
   input wire logic [13:0] current_ref,
   input wire logic [8:0] hyst_scale,
   input wire logic coil_freewheel,
   input wire logic coil_short
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!arst_n);
   // Scale must sit still two cycles; current_ref and hyst_scale are registered from it in the same cycle
   property p_ref_multiple;
      (hyst_scale != 9'h000 && $past(hyst_scale) == hyst_scale && $past(hyst_scale, 2) == hyst_scale)
      |-> (current_ref % hyst_scale == 0) && (current_ref / hyst_scale inside {[1:32]});
   endproperty
   a_ref_multiple: assert property (p_ref_multiple) else $error("current_ref not scale times level");
   property p_hyst_range;
      $past(arst_n) |-> hyst_scale inside {[9'h001:9'h100]};
   endproperty
   a_hyst_range: assert property (p_hyst_range) else $error("hyst_scale out of range");
   property p_defaults_stable;
      ($past(arst_n, 2) && $past(arst_n)) |-> $stable({blank_time_select, digital_deadtime_clocks,
         ground_short_threshold, supply_short_threshold, osc_trim});
   endproperty
   a_defaults_stable: assert property (p_defaults_stable) else $error("defaults moved");
   property p_blank_code;
      $past(arst_n) |-> blank_time_select inside {2'h1, 2'h2};
   endproperty
   a_blank_code: assert property (p_blank_code) else $error("blank default illegal");
   property p_deadtime_code;
      $past(arst_n) |-> digital_deadtime_clocks inside {4'h2, 4'h4};
   endproperty
   a_deadtime_code: assert property (p_deadtime_code) else $error("deadtime default illegal");
   property p_short_pair;
      $past(arst_n) |-> ground_short_threshold == supply_short_threshold
         && ground_short_threshold inside {4'h6, 4'hc};
   endproperty
   a_short_pair: assert property (p_short_pair) else $error("short defaults differ");
   property p_coil_quiet;
      (coil_freewheel || coil_short) |-> $past(quiet_pwm_mode) && !(coil_freewheel && coil_short);
   endproperty
   a_coil_quiet: assert property (p_coil_quiet) else $error("coil mode outside quiet mode");
   property p_coil_select;
      (coil_short |-> $past(standstill_short_sel)) and (coil_freewheel |-> !$past(standstill_short_sel));
   endproperty
   a_coil_select: assert property (p_coil_select) else $error("coil mode ignores select");
   property p_oe_idle;
      ($past(spi_cs_n, 2) && $past(spi_cs_n)) |-> spi_sdo_oe_n;
   endproperty
   a_oe_idle: assert property (p_oe_idle) else $error("sdo driven while deselected");
endmodule

bind mcs_top mcs_top_assertions mcs_top_assertions_i (.*);

/* dv/mcs_top_test.sv */
// Self-checking bench of the current scale block
`timescale 1ns/1ns
module mcs_top_test;
   logic mclk = 1'b0, arst_n = 1'b0, cs_n = 1'b1, sck = 1'b1, sdi = 1'b0, sdo, oe_n;
   logic fpe = 1'b0, ss = 1'b0, pde = 1'b0, qm = 1'b0, ssel = 1'b0, fw, csh;
   logic [7:0] offa = 8'h00, offb = 8'h00, fpb = 8'h00;
   logic [1:0] blank;
   logic [3:0] dead, gsh, vsh;
   logic [4:0] trim;
   logic [13:0] cur;
   logic [8:0] hyst;
   int fail_count = 0, num_checks = 0;
   // Short ramp unit keeps the hold ramp to a few dozen cycles
   mcs_top #(.RAMP_UNIT_CLKS(4)) mcs_top_i (.mclk(mclk), .arst_n(arst_n), .spi_cs_n(cs_n),
      .spi_sck(sck), .spi_sdi(sdi), .spi_sdo(sdo), .spi_sdo_oe_n(oe_n), .offset_cal_a(offa),
      .offset_cal_b(offb), .fuse_prog_en(fpe), .fuse_prog_bits(fpb), .standstill(ss),
      .powerdown_expired(pde), .quiet_pwm_mode(qm), .standstill_short_sel(ssel),
      .blank_time_select(blank), .digital_deadtime_clocks(dead), .ground_short_threshold(gsh),
      .supply_short_threshold(vsh), .osc_trim(trim), .current_ref(cur), .hyst_scale(hyst),
      .coil_freewheel(fw), .coil_short(csh));
   always #5 mclk = ~mclk;
   // ==========================================================
   // Helpers
   task automatic cyc(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
      num_checks++;
      if (s !== e) begin
         fail_count++;
         $display("[FAIL] %s expected %h seen %h", n, e, s);
      end
   endtask
   // Every sck phase spans three mclk edges, above the two-cycle minimum
   task automatic spi(input logic [39:0] tx, output logic [39:0] rx);
      cs_n = 1'b0;
      cyc(3);
      chk("sdo enable", {31'h0, oe_n}, 32'h0);
      for (int i = 39; i >= 0; i--) begin
         sck = 1'b0;
         sdi = tx[i];
         cyc(3);
         rx = {rx[38:0], sdo};
         sck = 1'b1;
         cyc(3);
      end
      cs_n = 1'b1;
      cyc(4);
   endtask
   task automatic wr(input logic [6:0] a, input logic [31:0] d);
      logic [39:0] r;
      spi({1'b1, a, d}, r);
   endtask
   // Answer of a read arrives in the following frame
   task automatic rd(input logic [6:0] a, output logic [31:0] d);
      logic [39:0] r;
      spi({1'b0, a, 32'h0}, r);
      spi({1'b0, a, 32'h0}, r);
      chk("status", {24'h0, r[39:32]}, 32'h0);
      d = r[31:0];
   endtask
   task automatic wait_ref(input logic [13:0] e, input int lim, output int n);
      n = 0;
      while (cur !== e && n < lim) begin
         cyc(1);
         n++;
      end
      chk("current_ref", cur, e);
      // A wait that ran out has just counted its mismatch above
      if (cur !== e) print_verdict;
   endtask
   // ==========================================================
   // Scenarios
   task automatic t_defaults;
      logic [31:0] d;
      chk("blank", blank, 2'h2);
      chk("deadtime", dead, 4'h4);
      chk("gnd short", gsh, 4'h6);
      chk("vs short", vsh, 4'h6);
      chk("trim", trim, mcs_pkg::FUSE_FACTORY_DEF[4:0]);
      chk("hyst", hyst, 9'h100);
      chk("ref", cur, 14'h0100);
      rd(mcs_pkg::ADDR_FUSE_READBACK, d);
      chk("fuse", d, {24'h0, mcs_pkg::FUSE_FACTORY_DEF});
   endtask
   task automatic t_scale;
      // No code from 1 to 31 is used; full scale is left for the later scenarios
      logic [7:0] sv [4] = '{8'h20, 8'h80, 8'hff, 8'h00};
      logic [8:0] e;
      logic [31:0] d;
      wr(mcs_pkg::ADDR_CURRENT_LEVELS, 32'h00000f03);
      foreach (sv[i]) begin
         wr(mcs_pkg::ADDR_CURRENT_SCALE_FACTOR, {24'h0, sv[i]});
         e = (sv[i] == 8'h00) ? 9'h100 : {1'b0, sv[i]};
         cyc(3);
         chk("hyst", hyst, e);
         chk("ref", cur, e * 16);
      end
      rd(mcs_pkg::ADDR_CURRENT_SCALE_FACTOR, d);
      chk("scale read", d, 32'h0);
   endtask
   task automatic t_offset;
      logic [31:0] d;
      offa = 8'h9c;
      offb = 8'h05;
      wr(mcs_pkg::ADDR_OFFSET_CAL_RESULT, 32'h0000ffff);
      rd(mcs_pkg::ADDR_OFFSET_CAL_RESULT, d);
      chk("offset", d, 32'h00009c05);
      rd(7'h05, d);
      chk("unmapped", d, 32'h0);
   endtask
   // Trim bits are offered for programming but must stay at the factory value
   task automatic t_fuse;
      logic [31:0] d;
      fpe = 1'b1;
      fpb = 8'hef;
      cyc(1);
      fpb = 8'h00;
      cyc(2);
      fpe = 1'b0;
      rd(mcs_pkg::ADDR_FUSE_READBACK, d);
      chk("fuse", d, {24'h0, mcs_pkg::FUSE_FACTORY_DEF | 8'he0});
      chk("blank kept", blank, 2'h2);
   endtask
   task automatic t_hold;
      int n;
      wr(mcs_pkg::ADDR_CURRENT_LEVELS, 32'h00001404);
      ss = 1'b1;
      cyc(20);
      chk("ref no expiry", cur, 14'd5376);
      pde = 1'b1;
      wait_ref(14'd1280, 5, n);
      ss = 1'b0;
      wait_ref(14'd5376, 5, n);
      wr(mcs_pkg::ADDR_CURRENT_LEVELS, 32'h00011404);
      ss = 1'b1;
      wait_ref(14'd1280, 400, n);
      chk("ramp length", 32'(n >= 60), 32'h1);
      ss = 1'b0;
   endtask
   task automatic t_coil;
      int n;
      wr(mcs_pkg::ADDR_CURRENT_LEVELS, 32'h00001400);
      qm = 1'b1;
      ss = 1'b1;
      wait_ref(14'h0100, 10, n);
      cyc(2);
      chk("freewheel", {fw, csh}, 2'b10);
      ssel = 1'b1;
      cyc(3);
      chk("shorted", {fw, csh}, 2'b01);
      qm = 1'b0;
      cyc(3);
      chk("quiet off", {fw, csh}, 2'b00);
   endtask
   initial begin
      repeat (5) @(posedge mclk);
      #1;
      arst_n = 1'b1;
      cyc(2);
      t_defaults;
      t_scale;
      t_offset;
      t_fuse;
      t_hold;
      t_coil;
      print_verdict;
   end
endmodule
